/* File: sbsram_core.sv */
// Synchronous pipelined-burst SRAM core, 64K x 18, with burst counter.
// Assumes far-side controller logic on the same clock; data pins split
// into in, out and output enable (enable low means driving).
module sbsram_core
    import sbsram_pkg::*;
#(
    parameter int AW = sbsram_pkg::ADDR_W,
    parameter int DW = sbsram_pkg::DATA_W
) (
    input  wire logic          clock,
    input  wire logic          sys_rst,
    input  wire logic [AW-1:0] addr,
    input  wire logic          chip_sel_n,
    input  wire logic          cpu_load_strobe_n,
    input  wire logic          cache_load_strobe_n,
    input  wire logic          step_n,
    input  wire logic          lower_byte_store_n,
    input  wire logic          upper_byte_store_n,
    input  wire logic          out_en_n,
    input  wire logic [DW-1:0] io_bus_in,
    output logic      [DW-1:0] io_bus_out,
    output logic               io_bus_oe_n,
    output logic               rd_valid,
    input  wire logic          rd_ready
);
    import sbsram_pkg::*;

    // ****************************************************************
    // Input registers
    // ****************************************************************
    logic [AW-1:0] addr_q, addr_d;
    logic [DW-1:0] din_q, din_d;
    logic          sel_n_q, cpu_n_q, cache_n_q, step_n_q, lo_n_q, hi_n_q;
    logic          sel_n_d, cpu_n_d, cache_n_d, step_n_d, lo_n_d, hi_n_d;
    logic          oe_n_s1_q, oe_n_s1_d, oe_n_s2_q, oe_n_s2_d;

    // All synchronous inputs except rd_ready captured on the rising edge; rd_ready goes straight to the FIFO
    always_comb begin
        addr_d    = addr;
        din_d     = io_bus_in;
        sel_n_d   = chip_sel_n;
        cpu_n_d   = cpu_load_strobe_n;
        cache_n_d = cache_load_strobe_n;
        step_n_d  = step_n;
        lo_n_d    = lower_byte_store_n;
        hi_n_d    = upper_byte_store_n;
        oe_n_s1_d = out_en_n;             // Pin from outside: two stages
        oe_n_s2_d = oe_n_s1_q;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            addr_q    <= ADDR_RST;
            din_q     <= '0;
            sel_n_q   <= 1'b1;
            cpu_n_q   <= 1'b1;
            cache_n_q <= 1'b1;
            step_n_q  <= 1'b1;
            lo_n_q    <= 1'b1;
            hi_n_q    <= 1'b1;
            oe_n_s1_q <= 1'b1;
            oe_n_s2_q <= 1'b1;
        end else begin
            addr_q    <= addr_d;
            din_q     <= din_d;
            sel_n_q   <= sel_n_d;
            cpu_n_q   <= cpu_n_d;
            cache_n_q <= cache_n_d;
            step_n_q  <= step_n_d;
            lo_n_q    <= lo_n_d;
            hi_n_q    <= hi_n_d;
            oe_n_s1_q <= oe_n_s1_d;
            oe_n_s2_q <= oe_n_s2_d;
        end
    end

    // ****************************************************************
    // Burst control
    // ****************************************************************
    logic [AW-1:0] base_q, base_d;
    logic [1:0]    cnt_q, cnt_d;
    logic          active_q, active_d;
    logic [AW-1:0] acc_addr;
    sbsram_op_t    op;
    logic          load, any_store;

    // A fresh base load overrides any burst; strobes are acted on the
    // cycle after capture, one cycle of pipeline through the registers
    always_comb begin
        load      = !cpu_n_q || !cache_n_q;
        any_store = !lo_n_q || !hi_n_q;
        base_d    = base_q;
        cnt_d     = cnt_q;
        active_d  = active_q;
        op        = SBSRAM_IDLE;
        if (load) begin
            if (!sel_n_q) begin
                base_d   = addr_q;
                cnt_d    = CNT_RST;
                active_d = 1'b1;
                if (!cpu_n_q) begin
                    op = SBSRAM_READ;
                end else begin
                    op = any_store ? SBSRAM_WRITE : SBSRAM_READ;
                end
            end else begin
                active_d = 1'b0;
            end
        end else if (active_q) begin
            if (!step_n_q) begin
                cnt_d = cnt_q + 2'h1;
            end                           // holds the count
            op = any_store ? SBSRAM_WRITE : SBSRAM_READ;
        end
        // Interleaved order, upper bits fixed
        acc_addr = {base_d[AW-1:BURST_W],
                    base_d[BURST_W-1:0] ^ cnt_d};
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            base_q   <= ADDR_RST;
            cnt_q    <= CNT_RST;
            active_q <= 1'b0;
        end else begin
            base_q   <= base_d;
            cnt_q    <= cnt_d;
            active_q <= active_d;
        end
    end

    // ****************************************************************
    // Array
    // ****************************************************************
    // No reset on the array: contents are undefined at power up
    logic [DW-1:0] mem [2**AW];
    logic [DW-1:0] rdata;
    logic          do_read, do_write;

    always_comb begin
        do_read  = (op == SBSRAM_READ);
        do_write = (op == SBSRAM_WRITE);
        rdata    = mem[acc_addr];
    end

    // Per-lane merge; a disabled lane writes back what it already holds
    logic [DW-1:0] wr_word;

    for (genvar g = 0; g < 2; g++) begin : g_lane
        logic lane_n;
        assign lane_n = (g == 0) ? lo_n_q : hi_n_q;
        assign wr_word[g*LANE_W +: LANE_W] = lane_n ? rdata[g*LANE_W +: LANE_W]
                                                    : din_q[g*LANE_W +: LANE_W];
    end

    // One writer for the whole array, committed at the clock edge so no strobe is needed
    always_ff @(posedge clock) begin
        if (do_write) begin
            mem[acc_addr] <= wr_word;
        end
    end

    // ****************************************************************
    // Read path through FIFO
    // ****************************************************************
    // Read data is queued; a read into a full queue is lost, so the
    // consumer must keep rd_ready high often enough to leave room
    logic          f_in_ready, f_valid;
    logic [DW-1:0] f_data;

    sbsram_fifo #(
        .WIDTH (DW),
        .DEPTH (FIFO_DEPTH)
    ) u_rd_fifo (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .in_valid  (do_read),
        .in_ready  (f_in_ready),
        .in_data   (rdata),
        .out_valid (f_valid),
        .out_ready (rd_ready),
        .out_data  (f_data)
    );

    // ****************************************************************
    // Output stage
    // ****************************************************************
    logic [DW-1:0] dout_q, dout_d;
    logic          oe_n_q, oe_n_d, rdv_q, rdv_d, last_rd_q, last_rd_d;

    // Drive only for a held read with output enable low
    always_comb begin
        last_rd_d = do_read ? 1'b1 : (do_write || (load && sel_n_q)) ? 1'b0 : last_rd_q;
        dout_d    = f_valid ? f_data : dout_q;
        rdv_d     = f_valid;
        oe_n_d    = !(last_rd_d && !oe_n_s2_q && !do_write);
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            dout_q    <= '0;
            oe_n_q    <= 1'b1;
            rdv_q     <= 1'b0;
            last_rd_q <= 1'b0;
        end else begin
            dout_q    <= dout_d;
            oe_n_q    <= oe_n_d;
            rdv_q     <= rdv_d;
            last_rd_q <= last_rd_d;
        end
    end

    assign io_bus_out  = dout_q;
    assign io_bus_oe_n = oe_n_q;
    assign rd_valid    = rdv_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_no_drive_write: assert property (@(posedge clock) disable iff (sys_rst)
        do_write |=> io_bus_oe_n) else $error("driving during write");
    a_deselect_quiet: assert property (@(posedge clock) disable iff (sys_rst)
        (load && sel_n_q) |=> (io_bus_oe_n && !active_q)) else $error("deselect not quiet");
    a_cpu_read: assert property (@(posedge clock) disable iff (sys_rst)
        (!cpu_n_q && !sel_n_q) |-> (op == SBSRAM_READ)) else $error("cpu strobe not read");
    a_cache_write: assert property (@(posedge clock) disable iff (sys_rst)
        (cpu_n_q && !cache_n_q && !sel_n_q && any_store) |-> do_write)
        else $error("cache strobe write lost");
    a_step_adv: assert property (@(posedge clock) disable iff (sys_rst)
        (!load && active_q && !step_n_q) |=> (cnt_q == $past(cnt_q) + 2'h1))
        else $error("step did not advance");
    a_suspend_hold: assert property (@(posedge clock) disable iff (sys_rst)
        (!load && step_n_q) |=> $stable(cnt_q)) else $error("suspend moved count");
    a_base_fixed: assert property (@(posedge clock) disable iff (sys_rst)
        !load |-> (acc_addr[AW-1:BURST_W] == base_q[AW-1:BURST_W]))
        else $error("upper address moved");
    a_load_base: assert property (@(posedge clock) disable iff (sys_rst)
        (load && !sel_n_q) |=> (cnt_q == CNT_RST && base_q == $past(addr_q)))
        else $error("base not loaded");
    a_oe_gate: assert property (@(posedge clock) disable iff (sys_rst)
        oe_n_s2_q |=> io_bus_oe_n) else $error("driving with enable high");
endmodule

/* File: sbsram_ctl_model.sv */
// Far-side controller model: drives load, burst and store cycles.
// Assumes the bench calls cyc once per clock; signals change at falling edges.
module sbsram_ctl_model (
    input  wire logic        clock,
    input  wire logic        oe_off,
    output logic      [15:0] addr,
    output logic             chip_sel_n,
    output logic             cpu_load_strobe_n,
    output logic             cache_load_strobe_n,
    output logic             step_n,
    output logic             lower_byte_store_n,
    output logic             upper_byte_store_n,
    output logic             out_en_n,
    output logic      [17:0] io_bus_in
);
    logic wr_prev;
    // Quiet bus at time zero
    initial begin
        {cpu_load_strobe_n, cache_load_strobe_n, step_n, chip_sel_n} = 4'hf;
        {lower_byte_store_n, upper_byte_store_n, out_en_n} = 3'h7;
        addr = 16'h0000;
        io_bus_in = 18'h00000;
        wr_prev = 1'b0;
    end
    // One cycle; kind 0 cpu load, 1 cache load, 2 continue or suspend
    task automatic cyc(input logic [1:0] kind, input logic sel_n, stp_n, lw_n, uw_n,
                       input logic [15:0] a, input logic [17:0] d);
        logic wr;
        @(negedge clock);
        wr = (kind != 2'h0) && !(lw_n && uw_n);
        cpu_load_strobe_n = (kind != 2'h0);
        cache_load_strobe_n = (kind != 2'h1);
        chip_sel_n = sel_n;
        step_n = stp_n;
        addr = a;
        lower_byte_store_n = lw_n;
        upper_byte_store_n = uw_n;
        // Enable held off around writes so both ends never drive at once
        out_en_n = oe_off | wr | wr_prev;
        io_bus_in = wr ? d : ~io_bus_in; // Released bus toggles, never stale
        wr_prev = wr;
    endtask
endmodule

/* File: sbsram_fifo.sv */
// Small synchronous FIFO with valid and ready on both sides.
// Assumes one clock; reset is asynchronous, active high.
module sbsram_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 4
) (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [PW:0]      cnt_q, cnt_d;
    logic             push, pop;

    // ****************************************************************
    // Pointers
    // ****************************************************************
    // Honest flags straight from the occupancy count
    always_comb begin
        in_ready  = (cnt_q != (PW+1)'(DEPTH));
        out_valid = (cnt_q != '0);
        out_data  = mem_q[rd_q];
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        wr_d      = push ? ((wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + PW'(1)) : wr_q;
        rd_d      = pop ? ((rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + PW'(1)) : rd_q;
        cnt_d     = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage has no reset; contents are don't-care until written
    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule

/* File: sbsram_pkg.sv */
// Shared constants for the synchronous burst SRAM core.
// Assumes a single 100 MHz clock domain and no software-visible registers.
package sbsram_pkg;
    // ****************************************************************
    // Geometry
    // ****************************************************************
    localparam int ADDR_W     = 16;
    localparam int DATA_W     = 18;
    localparam int DEPTH      = 65536;
    localparam int LANE_LO    = 0;     // Lower byte lane starts at bit 0
    localparam int LANE_HI    = 9;     // Upper byte lane starts at bit 9
    localparam int LANE_W     = 9;
    localparam int BURST_W    = 2;
    localparam int FIFO_DEPTH = 4;
    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [1:0]  CNT_RST  = 2'h0;
    localparam logic [15:0] ADDR_RST = 16'h0000;
    // ****************************************************************
    // Cycle kinds
    // ****************************************************************
    typedef enum logic [1:0] {
        SBSRAM_IDLE,
        SBSRAM_READ,
        SBSRAM_WRITE
    } sbsram_op_t;
endpackage

/* File: testbench.sv */
// Self-checking bench for the burst SRAM core with a controller model.
// Assumes rd_ready mostly high, since reads into a full queue are dropped.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sbsram_pkg::*;
    logic        clock, sys_rst, rd_ready, oe_off, act;
    wire  [15:0] addr;
    wire         chip_sel_n, cpu_ls_n, cache_ls_n, step_n, lw_n, uw_n, out_en_n;
    wire  [17:0] io_bus_in;
    logic [17:0] io_bus_out;
    logic        io_bus_oe_n, rd_valid;
    logic [17:0] mem [int];
    logic [17:0] q [$];
    logic [15:0] base;
    logic [1:0]  cnt;
    int          fails, compares, seed;
    logic        rdy_seen;
    // ****************************************************************
    // Instances and clock
    // ****************************************************************
    sbsram_core u_dut (.clock(clock), .sys_rst(sys_rst), .addr(addr),
        .chip_sel_n(chip_sel_n), .cpu_load_strobe_n(cpu_ls_n),
        .cache_load_strobe_n(cache_ls_n), .step_n(step_n), .lower_byte_store_n(lw_n),
        .upper_byte_store_n(uw_n), .out_en_n(out_en_n), .io_bus_in(io_bus_in),
        .io_bus_out(io_bus_out), .io_bus_oe_n(io_bus_oe_n), .rd_valid(rd_valid),
        .rd_ready(rd_ready));
    sbsram_ctl_model u_ctl (.clock(clock), .oe_off(oe_off), .addr(addr),
        .chip_sel_n(chip_sel_n), .cpu_load_strobe_n(cpu_ls_n),
        .cache_load_strobe_n(cache_ls_n), .step_n(step_n), .lower_byte_store_n(lw_n),
        .upper_byte_store_n(uw_n), .out_en_n(out_en_n), .io_bus_in(io_bus_in));
    initial clock = 1'b0;
    always #5 clock = ~clock;
    // ****************************************************************
    // Checking, model and verdict
    // ****************************************************************
    task automatic check(input string nm, input logic [17:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Reference burst model; expected reads queued before the cycle goes out
    task automatic op(input logic [1:0] kind, input logic sel_n, stp_n, l_n, u_n,
                      input logic [15:0] a);
        logic [17:0] d;
        logic [15:0] ea;
        logic        go;
        d = 18'($random(seed));
        go = 1'b0;
        if (kind != 2'h2) begin
            act = !sel_n;
            base = a;
            cnt = 2'h0;
            go = act;
        end else if (act) begin
            if (!stp_n) cnt = cnt + 2'h1;
            go = 1'b1;
        end
        ea = {base[15:2], base[1:0] ^ cnt};
        if (go && kind != 2'h0 && !(l_n && u_n))
            mem[ea] = {u_n ? mem[ea][17:9] : d[17:9], l_n ? mem[ea][8:0] : d[8:0]};
        else if (go) q.push_back(mem[ea]);
        u_ctl.cyc(kind, sel_n, stp_n, l_n, u_n, a, d);
    endtask
    // Ready as seen by the queue at the edge; a word counts only once popped
    always @(posedge clock) rdy_seen <= rd_ready;
    // Read watcher: oldest expectation against each popped word, off the edge
    always @(negedge clock) begin
        if (!sys_rst && rd_valid === 1'b1 && rdy_seen === 1'b1) begin
            check("read queued", {17'h0, q.size() != 0}, 18'h1);
            if (q.size() != 0) check("read data", io_bus_out, q.pop_front());
        end
    end
    initial begin
        #100000;
        fails++;
        results();
    end
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        {sys_rst, rd_ready, oe_off, act, base, cnt} = {3'h6, 1'b0, 16'h0, 2'h0};
        fails = 0;
        compares = 0;
        seed = 67;
        repeat (4) @(posedge clock);
        @(negedge clock) sys_rst = 1'b0;
        check("oe after reset", {17'h0, io_bus_oe_n}, 18'h1);
        // Write burst, wait state on second step, select ignored mid-burst
        op(2'h1, 1'b0, 1'b1, 1'b0, 1'b0, 16'h1236);
        for (int i = 0; i < 4; i++) op(2'h2, 1'b1, i == 1, 1'b0, 1'b0, 16'hffff);
        // Read burst of five wraps; store enables on the load are ignored
        op(2'h0, 1'b0, 1'b1, 1'b0, 1'b0, 16'h1236);
        for (int i = 0; i < 4; i++) op(2'h2, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0000);
        check("oe driving read", {17'h0, io_bus_oe_n}, 18'h0);
        // Single-lane writes, then read back
        op(2'h1, 1'b0, 1'b1, 1'b0, 1'b1, 16'h1237);
        op(2'h1, 1'b0, 1'b1, 1'b1, 1'b0, 16'h1234);
        op(2'h0, 1'b0, 1'b1, 1'b1, 1'b1, 16'h1237);
        op(2'h0, 1'b0, 1'b1, 1'b1, 1'b1, 16'h1234);
        op(2'h1, 1'b0, 1'b1, 1'b1, 1'b1, 16'h1234);
        // One-cycle write after a cpu load (load cycle itself reads)
        op(2'h0, 1'b0, 1'b1, 1'b1, 1'b1, 16'h1235);
        op(2'h2, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0000);
        op(2'h0, 1'b0, 1'b1, 1'b1, 1'b1, 16'h1235);
        // Deselected load writes nothing and ends the burst
        op(2'h1, 1'b1, 1'b1, 1'b0, 1'b0, 16'h1236);
        repeat (3) op(2'h2, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0000);
        check("oe deselected", {17'h0, io_bus_oe_n}, 18'h1);
        op(2'h0, 1'b0, 1'b1, 1'b1, 1'b1, 16'h1236);
        // Let the last read leave, then fill the queue exactly with consumer stalled
        repeat (3) op(2'h1, 1'b1, 1'b1, 1'b1, 1'b1, 16'h0000);
        rd_ready = 1'b0;
        op(2'h0, 1'b0, 1'b1, 1'b1, 1'b1, 16'h1234);
        repeat (3) op(2'h2, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0000);
        repeat (3) op(2'h1, 1'b1, 1'b1, 1'b1, 1'b1, 16'h0000);
        check("queue held", {17'h0, rd_valid}, 18'h1);
        rd_ready = 1'b1;
        // Output enable off: pins stay released during reads
        oe_off = 1'b1;
        repeat (3) op(2'h1, 1'b1, 1'b1, 1'b1, 1'b1, 16'h0000);
        op(2'h0, 1'b0, 1'b1, 1'b1, 1'b1, 16'h1237);
        for (int i = 0; i < 4; i++) begin
            op(2'h2, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0000);
            check("oe held off", {17'h0, io_bus_oe_n}, 18'h1);
        end
        oe_off = 1'b0;
        repeat (8) op(2'h1, 1'b1, 1'b1, 1'b1, 1'b1, 16'h0000);
        check("reads left", 18'(q.size()), 18'h0);
        results();
    end
endmodule
